// ### verilog/spl_checker.sv
// Soft position limit supervision with per-segment link flags.
// Assumes the profile generator pulses move requests and reports position each cycle.
//
// Operation
// (R1) Limit writes are signed and clipped to plus or minus 8,388,607 steps.
// (R2) After reset the lower limit is -8,388,607 and the upper limit +8,388,607.
// (R3) A limit write takes effect at once and pulses a save strobe to nonvolatile memory.
// (R4) Limits are enforced only when enabled and a homing action has completed.
// (R5) A violation stops the motor and, per alarm action, raises code 67h and removes current.
// (R6) The stop on a limit violation is always a soft stop.
// (R7) Checking is suspended while homing is in progress.
// (R8) On homing completion with zero outside the window an alarm may be raised at once.
// (R9) Index move targets are checked before motion; an outside target is refused and alarmed.
// (R10) Continuous moves flag a violation only when the position actually crosses out; the code flags every idle cycle with the position outside.
// (R11) When outside and alarm cleared, an index move to a target inside is accepted.
// (R12) When outside, a continuous move is accepted only toward the permitted range.
// (R13) Segments 0 to 2 each have a link flag: 0 ends motion, 1 continues to the next.
// (R14) Link flags reset to 0, apply when written and persist only on explicit save.
// (R15) A position equal to a limit is inside; only strictly beyond is a violation.
`timescale 1ns/1ns
module spl_checker (
    // Clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        reset_in,
    // Limit configuration
    input  wire logic        lower_limit_wr_in,
    input  wire logic        upper_limit_wr_in,
    input  wire logic [23:0] limit_data_in,
    input  wire logic        soft_limit_enable_in,
    input  wire logic [1:0]  alarm_action_select_in,
    input  wire logic        alarm_clear_in,
    // Homing status
    input  wire logic        homing_busy_in,
    input  wire logic        homing_done_in,
    input  wire logic        position_zeroed_in,
    // Position and move requests
    input  wire logic [23:0] position_setpoint_in,
    input  wire logic        index_move_req_in,
    input  wire logic [23:0] index_target_in,
    input  wire logic        continuous_move_positive_in,
    input  wire logic        continuous_move_negative_in,
    // Link flags
    input  wire logic        link_wr_in,
    input  wire logic [1:0]  link_sel_in,
    input  wire logic        link_data_in,
    input  wire logic        parameter_save_command_in,
    input  wire logic [2:0]  link_restore_in,
    input  wire logic        link_restore_valid_in,
    // Configuration readback and save
    output logic [23:0]      lower_position_limit_out,
    output logic [23:0]      upper_position_limit_out,
    output logic             limit_save_out,
    output logic [2:0]       segment_link_flag_out,
    output logic [2:0]       link_save_data_out,
    output logic             link_save_out,
    // Move decisions and alarm
    output logic             move_accept_out,
    output logic             move_refuse_out,
    output logic             soft_stop_out,
    output logic             alarm_out,
    output logic [7:0]       alarm_code_out,
    output logic             current_off_out,
    output logic             homed_out
);

    ////////////////////////////////////////////////////////////////////////////
    logic signed [23:0]      lower_r;
    logic signed [23:0]      upper_r;
    logic signed [23:0]      wr_val;
    logic                    homed_r;
    logic                    alarm_r;
    logic                    checking;
    logic                    pos_below;
    logic                    pos_above;
    logic                    tgt_below;
    logic                    tgt_above;
    logic                    zero_below;
    logic                    zero_above;
    logic                    pos_out;
    logic                    any_req;
    logic                    req_ok;
    logic                    violation;
    logic                    zero_bad;
    logic                    trip;

    ////////////////////////////////////////////////////////////////////////////
    // Clip out of range writes; -8,388,608 is the only 24-bit value beyond
    always_comb begin
        wr_val = signed'(limit_data_in);
        if (limit_data_in == 24'h800000) begin
            wr_val = signed'(spl_pkg::POS_MIN);  // R1
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            lower_r <= signed'(spl_pkg::LOWER_RESET);  // R2
            upper_r <= signed'(spl_pkg::UPPER_RESET);  // R2
        end else begin
            if (lower_limit_wr_in) begin
                lower_r <= wr_val;  // R3
            end
            if (upper_limit_wr_in) begin
                upper_r <= wr_val;  // R3
            end
        end
    end

    // Limits save themselves; no save command needed
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            limit_save_out <= 1'b0;
        end else begin
            limit_save_out <= lower_limit_wr_in | upper_limit_wr_in;  // R3
        end
    end

    assign lower_position_limit_out = lower_r;
    assign upper_position_limit_out = upper_r;

    ////////////////////////////////////////////////////////////////////////////
    spl_range_cmp u_pos (
        .pos_in    (signed'(position_setpoint_in)),
        .lower_in  (lower_r),
        .upper_in  (upper_r),
        .below_out (pos_below),
        .above_out (pos_above)
    );
    spl_range_cmp u_tgt (
        .pos_in    (signed'(index_target_in)),
        .lower_in  (lower_r),
        .upper_in  (upper_r),
        .below_out (tgt_below),
        .above_out (tgt_above)
    );
    spl_range_cmp u_zero (
        .pos_in    (24'sh000000),
        .lower_in  (lower_r),
        .upper_in  (upper_r),
        .below_out (zero_below),
        .above_out (zero_above)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Homed flag; homing in progress drops it until done or position zeroed
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            homed_r <= 1'b0;
        end else if (homing_busy_in) begin
            homed_r <= 1'b0;  // R7
        end else if (homing_done_in || position_zeroed_in) begin
            homed_r <= 1'b1;  // R4
        end
    end

    assign checking  = soft_limit_enable_in && homed_r && !homing_busy_in;  // R4 R7
    assign pos_out   = pos_below | pos_above;
    assign any_req   = index_move_req_in | continuous_move_positive_in
                     | continuous_move_negative_in;

    // Move admission
    always_comb begin
        req_ok = 1'b1;
        if (alarm_r) begin
            req_ok = 1'b0;
        end else if (checking) begin
            if (index_move_req_in) begin
                req_ok = !(tgt_below | tgt_above);  // R9 R11
            end else if (continuous_move_positive_in) begin
                req_ok = !pos_above;  // R12
            end else if (continuous_move_negative_in) begin
                req_ok = !pos_below;  // R12
            end
        end
    end

    // Level check: the set point outside a limit on any cycle with no move request
    assign violation = checking && !alarm_r && pos_out && !any_req;  // R10
    assign zero_bad  = soft_limit_enable_in && homing_done_in && !homing_busy_in
                     && (zero_below | zero_above);  // R8
    assign trip      = violation || zero_bad
                     || (checking && index_move_req_in && !req_ok && !alarm_r);  // R9

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            move_accept_out <= 1'b0;
            move_refuse_out <= 1'b0;
        end else begin
            move_accept_out <= any_req && req_ok;
            move_refuse_out <= any_req && !req_ok;  // R9
        end
    end

    // Always a soft stop; no hard stop path exists
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            soft_stop_out <= 1'b0;
        end else begin
            soft_stop_out <= trip && !index_move_req_in;  // R5 R6
        end
    end

    // Set wins over clear
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            alarm_r         <= 1'b0;
            alarm_code_out  <= spl_pkg::ALARM_NONE;
            current_off_out <= 1'b0;
        end else if (trip && alarm_action_select_in != spl_pkg::ACT_STOP_ONLY) begin
            alarm_r         <= 1'b1;  // R5
            alarm_code_out  <= spl_pkg::ALARM_CODE_LIM;  // R5
            current_off_out <= alarm_action_select_in == spl_pkg::ACT_ALARM_OFF;  // R5
        end else if (alarm_clear_in) begin
            alarm_r         <= 1'b0;
            alarm_code_out  <= spl_pkg::ALARM_NONE;
            current_off_out <= 1'b0;
        end
    end

    assign alarm_out = alarm_r;
    assign homed_out = homed_r;

    ////////////////////////////////////////////////////////////////////////////
    // Link flags; restore path models power-up reload of the saved copy
    generate
        for (genvar i = 0; i < spl_pkg::SEG_N; i++) begin : g_link
            always_ff @(posedge core_clk_in) begin
                if (reset_in) begin
                    segment_link_flag_out[i] <= spl_pkg::LINK_RESET[i];  // R14
                end else if (link_wr_in && link_sel_in == 2'(i)) begin
                    segment_link_flag_out[i] <= link_data_in;  // R13 R14
                end else if (link_restore_valid_in) begin
                    segment_link_flag_out[i] <= link_restore_in[i];  // R14
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            link_save_out      <= 1'b0;
            link_save_data_out <= spl_pkg::LINK_RESET;
        end else begin
            link_save_out      <= parameter_save_command_in;  // R14
            if (parameter_save_command_in) begin
                link_save_data_out <= segment_link_flag_out;  // R14
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    a_refused_index: assert property (@(posedge core_clk_in) disable iff (reset_in)  // R9
        (checking && !alarm_r && index_move_req_in && (tgt_below | tgt_above))
        |=> move_refuse_out && !move_accept_out)
        else $error("out of range index target not refused");
    a_inside_index: assert property (@(posedge core_clk_in) disable iff (reset_in)  // R11
        (!alarm_r && index_move_req_in && !tgt_below && !tgt_above)
        |=> move_accept_out)
        else $error("inside index target not accepted");
    a_cont_back: assert property (@(posedge core_clk_in) disable iff (reset_in)  // R12
        (checking && !alarm_r && continuous_move_positive_in && pos_above)
        |=> move_refuse_out)
        else $error("continuous move away from range accepted");
    a_homing_quiet: assert property (@(posedge core_clk_in) disable iff (reset_in)  // R7
        homing_busy_in |=> !soft_stop_out)
        else $error("limit stop issued during homing");
    a_alarm_code: assert property (@(posedge core_clk_in) disable iff (reset_in)  // R5
        (violation && alarm_action_select_in == spl_pkg::ACT_ALARM_OFF)
        |=> alarm_out && current_off_out && alarm_code_out == 8'h67)
        else $error("alarm action not applied");
    a_soft_stop: assert property (@(posedge core_clk_in) disable iff (reset_in)  // R6
        violation |=> soft_stop_out)
        else $error("violation without soft stop");
    a_edge_inside: assert property (@(posedge core_clk_in) disable iff (reset_in)  // R15
        (signed'(position_setpoint_in) == upper_r) |-> !pos_above)
        else $error("limit value treated as outside");
    a_limit_write: assert property (@(posedge core_clk_in) disable iff (reset_in)  // R3
        (upper_limit_wr_in && !lower_limit_wr_in)
        |=> upper_r == $past(wr_val) && limit_save_out)
        else $error("limit write not applied and saved");
    a_link_write: assert property (@(posedge core_clk_in) disable iff (reset_in)  // R13
        (link_wr_in && link_sel_in == 2'h1)
        |=> segment_link_flag_out[1] == $past(link_data_in))
        else $error("link flag write lost");
endmodule

// ### inc/spl_pkg.sv
// Package for the soft position limit checker: widths, reset values, codes.
// Assumes a single 20 MHz clock domain and plain-port control bits.
package spl_pkg;
    localparam int          POS_W          = 24;
    localparam int          SEG_N          = 3;
    localparam logic [23:0] POS_MAX        = 24'h7FFFFF;
    localparam logic [23:0] POS_MIN        = 24'h800001;
    localparam logic [23:0] LOWER_RESET    = 24'h800001;
    localparam logic [23:0] UPPER_RESET    = 24'h7FFFFF;
    localparam logic [2:0]  LINK_RESET     = 3'h0;
    localparam logic [7:0]  ALARM_CODE_LIM = 8'h67;
    localparam logic [7:0]  ALARM_NONE     = 8'h00;
    // Alarm action select encoding
    localparam logic [1:0]  ACT_STOP_ONLY  = 2'h0;
    localparam logic [1:0]  ACT_ALARM      = 2'h1;
    localparam logic [1:0]  ACT_ALARM_OFF  = 2'h2;

    typedef enum logic [2:0] {
        SPL_IDLE  = 3'b001,
        SPL_HOME  = 3'b010,
        SPL_ARMED = 3'b100
    } spl_state_type;
endpackage

// ### verilog/spl_range_cmp.sv
// Inclusive signed window compare of one position against both limits.
// Assumes limits already clipped to the legal range.
`timescale 1ns/1ns
module spl_range_cmp (
    // Compared values
    input  wire logic signed [23:0] pos_in,
    input  wire logic signed [23:0] lower_in,
    input  wire logic signed [23:0] upper_in,
    // Result
    output logic                    below_out,
    output logic                    above_out
);
    // Equal to a limit counts as inside
    assign below_out = pos_in < lower_in;  // R15
    assign above_out = pos_in > upper_in;  // R15
endmodule

// ### verif/spl_profile_model.sv
// Behavioural profile generator that holds the commanded position set point.
// Assumes the bench loads or jogs it; a soft stop from the checker halts jogging.
`timescale 1ns/1ns
module spl_profile_model (
    // Clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        reset_in,
    // Bench control
    input  wire logic        load_in,
    input  wire logic [23:0] load_val_in,
    input  wire logic        jog_in,
    input  wire logic        soft_stop_in,
    // Position to the checker
    output logic [23:0]      position_out
);
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            position_out <= 24'h000000;
        end else if (load_in) begin
            position_out <= load_val_in;
        end else if (jog_in && !soft_stop_in) begin
            position_out <= position_out + 24'h000001;
        end
    end
endmodule

// ### verif/test_spl_checker.sv
// Self-checking bench for the soft position limit checker.
// Assumes one 20 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ns
module test_spl_checker;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        lo_wr = 1'b0, up_wr = 1'b0, en = 1'b0, clr = 1'b0;
    logic        busy = 1'b0, done = 1'b0, zeroed = 1'b0, ireq = 1'b0;
    logic        cpos = 1'b0, cneg = 1'b0, lwr = 1'b0, ldat = 1'b0;
    logic        save = 1'b0, rvalid = 1'b0, load = 1'b0, jog = 1'b0;
    logic [1:0]  act = 2'h0, lsel = 2'h0;
    logic [2:0]  rdat = 3'h0;
    logic [23:0] ldata = 24'h000000, itgt = 24'h000000, lval = 24'h000000, pos;
    logic [23:0] lo_o, up_o;
    logic [2:0]  lf_o, lsd_o;
    logic [7:0]  code_o;
    logic        lsv_o, lks_o, acc_o, ref_o, stop_o, alm_o, coff_o, hom_o;
    int          err_count = 0;
    int          n_tests = 0;

    always #25 clk = ~clk;

    spl_profile_model model (.core_clk_in(clk), .reset_in(rst), .load_in(load),
        .load_val_in(lval), .jog_in(jog), .soft_stop_in(stop_o), .position_out(pos));

    spl_checker uut (.core_clk_in(clk), .reset_in(rst), .lower_limit_wr_in(lo_wr),
        .upper_limit_wr_in(up_wr), .limit_data_in(ldata), .soft_limit_enable_in(en),
        .alarm_action_select_in(act), .alarm_clear_in(clr), .homing_busy_in(busy),
        .homing_done_in(done), .position_zeroed_in(zeroed), .position_setpoint_in(pos),
        .index_move_req_in(ireq), .index_target_in(itgt),
        .continuous_move_positive_in(cpos), .continuous_move_negative_in(cneg),
        .link_wr_in(lwr), .link_sel_in(lsel), .link_data_in(ldat),
        .parameter_save_command_in(save), .link_restore_in(rdat),
        .link_restore_valid_in(rvalid), .lower_position_limit_out(lo_o),
        .upper_position_limit_out(up_o), .limit_save_out(lsv_o),
        .segment_link_flag_out(lf_o), .link_save_data_out(lsd_o), .link_save_out(lks_o),
        .move_accept_out(acc_o), .move_refuse_out(ref_o), .soft_stop_out(stop_o),
        .alarm_out(alm_o), .alarm_code_out(code_o), .current_off_out(coff_o),
        .homed_out(hom_o));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, seen);
            err_count++;
        end
    endtask

    task automatic complete_run();
        $display("tests %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Each strobe task starts and ends at a falling edge
    task automatic wr_lim(input logic upper, input logic [23:0] v);
        ldata = v;
        up_wr = upper;
        lo_wr = !upper;
        @(negedge clk);
        up_wr = 1'b0;
        lo_wr = 1'b0;
    endtask

    task automatic idx(input logic [23:0] t);
        itgt = t;
        ireq = 1'b1;
        @(negedge clk);
        ireq = 1'b0;
    endtask

    task automatic set_pos(input logic [23:0] v);
        lval = v;
        load = 1'b1;
        @(negedge clk);
        load = 1'b0;
        @(negedge clk);
    endtask

    task automatic pulse_clr();
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #(3000 * 50);
        err_count++;
        complete_run();
    end

    initial begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk("lower reset", lo_o, 24'h800001);
        chk("upper reset", up_o, 24'h7FFFFF);
        chk("link reset", lf_o, 24'h0);
        wr_lim(1'b0, 24'h800000);
        chk("lower clip", lo_o, 24'h800001);
        wr_lim(1'b1, 24'h000064);
        chk("upper now", up_o, 24'h000064);
        chk("limit save", lsv_o, 24'h1);
        wr_lim(1'b0, 24'hFFFF9C);
        chk("lower now", lo_o, 24'hFFFF9C);
        for (int i = 0; i < 3; i++) begin
            lsel = i[1:0];
            ldat = 1'b1;
            lwr = 1'b1;
            @(negedge clk);
            lwr = 1'b0;
            chk("link flags", lf_o, (24'h2 << i) - 24'h1);
        end
        chk("no save yet", lks_o, 24'h0);
        save = 1'b1;
        @(negedge clk);
        save = 1'b0;
        chk("link save", lks_o, 24'h1);
        chk("link save data", lsd_o, 24'h7);
        rdat = 3'h2;
        rvalid = 1'b1;
        @(negedge clk);
        rvalid = 1'b0;
        chk("link restore", lf_o, 24'h2);
        en = 1'b1;
        act = 2'h1;
        set_pos(24'h0000C8);
        chk("unhomed stop", stop_o, 24'h0);
        chk("unhomed alarm", alm_o, 24'h0);
        set_pos(24'h000000);
        busy = 1'b1;
        @(negedge clk);
        busy = 1'b0;
        done = 1'b1;
        @(negedge clk);
        done = 1'b0;
        @(negedge clk);
        chk("homed", hom_o, 24'h1);
        chk("zero inside", alm_o, 24'h0);
        idx(24'h000065);
        chk("index refuse", ref_o, 24'h1);
        chk("index no go", acc_o, 24'h0);
        chk("alarm set", alm_o, 24'h1);
        chk("alarm code", code_o, 24'h67);
        pulse_clr();
        @(negedge clk);
        chk("alarm cleared", alm_o, 24'h0);
        idx(24'h000064);
        chk("edge target", acc_o, 24'h1);
        act = 2'h2;
        set_pos(24'h000063);
        jog = 1'b1;
        for (int n = 0; n < 20 && stop_o !== 1'b1; n++) @(negedge clk);
        jog = 1'b0;
        chk("cross point", pos, 24'h000066);
        chk("soft stop", stop_o, 24'h1);
        @(negedge clk);
        chk("current off", coff_o, 24'h1);
        act = 2'h0;
        pulse_clr();
        @(negedge clk);
        idx(24'h000032);
        chk("index back in", acc_o, 24'h1);
        cpos = 1'b1;
        @(negedge clk);
        cpos = 1'b0;
        chk("away refused", ref_o, 24'h1);
        cneg = 1'b1;
        @(negedge clk);
        cneg = 1'b0;
        chk("toward accepted", acc_o, 24'h1);
        busy = 1'b1;
        act = 2'h1;
        repeat (2) @(negedge clk);
        chk("busy no stop", stop_o, 24'h0);
        wr_lim(1'b0, 24'h00000A);
        set_pos(24'h000032);
        busy = 1'b0;
        done = 1'b1;
        @(negedge clk);
        done = 1'b0;
        chk("zero outside", alm_o, 24'h1);
        busy = 1'b1;
        @(negedge clk);
        busy = 1'b0;
        chk("homing drops", hom_o, 24'h0);
        zeroed = 1'b1;
        @(negedge clk);
        zeroed = 1'b0;
        chk("zeroed homes", hom_o, 24'h1);
        complete_run();
    end
endmodule
